// ### rtl/unbm_pkg.sv
// Purpose: constants and carriers for the nine-bit serial port (modes 2 and 3)
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes:
package unbm_pkg;

    localparam int            UNBM_AW        = 4;
    localparam logic [3:0]    UNBM_CTRL_OFS  = 4'h0;
    localparam logic [3:0]    UNBM_BUF_OFS   = 4'h4;
    localparam logic [3:0]    UNBM_STAT_OFS  = 4'h8;

    localparam int            UNBM_RXF_BIT   = 0;
    localparam int            UNBM_TXF_BIT   = 1;
    localparam int            UNBM_RB9_BIT   = 2;
    localparam int            UNBM_TB9_BIT   = 3;
    localparam int            UNBM_REN_BIT   = 4;
    localparam int            UNBM_MPF_BIT   = 5;
    localparam int            UNBM_MODE3_BIT = 6;
    localparam int            UNBM_DBL_BIT   = 7;
    localparam logic [7:0]    UNBM_CTRL_RST  = 8'h00;

    localparam logic [3:0]    UNBM_CNT_LAST  = 4'hf;
    localparam logic [3:0]    UNBM_SMP_A     = 4'h7;
    localparam logic [3:0]    UNBM_SMP_B     = 4'h8;
    localparam logic [3:0]    UNBM_SMP_C     = 4'h9;
    localparam logic [8:0]    UNBM_SHIFT_RST = 9'h1ff;

    localparam logic [1:0]    UNBM_OKAY      = 2'b00;
    localparam logic [1:0]    UNBM_SLVERR    = 2'b10;

    typedef struct packed {
        logic [UNBM_AW-1:0] awaddr;
        logic               awvalid;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               wvalid;
        logic               bready;
        logic [UNBM_AW-1:0] araddr;
        logic               arvalid;
        logic               rready;
    } unbm_axireq_type;

    typedef struct packed {
        logic               awready;
        logic               wready;
        logic [1:0]         bresp;
        logic               bvalid;
        logic               arready;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               rvalid;
    } unbm_axirsp_type;

    typedef struct packed {
        logic               load;
        logic               ninth;
        logic [7:0]         data;
    } unbm_rxres_type;

endpackage : unbm_pkg

// ### rtl/unbm_rx.sv
// Purpose: receive side of the nine-bit serial port
// Assumes: rxd_level already synchronised; sample_tick at 16x bit rate
// Notes: result.load is a one-cycle pulse
`timescale 1ns/10ps
module unbm_rx (
    input  wire logic                    aclk,             // Clock
    input  wire logic                    aresetn,          // Sync reset, low
    input  wire logic                    sample_tick,      // 16x bit-rate enable
    input  wire logic                    rxd_level,        // Filtered line
    input  wire logic                    rx_enable,        // Receiver on
    input  wire logic                    multiproc_filter, // Ninth-bit filter
    input  wire logic                    rx_done_flag,     // Current flag
    output logic                         rx_active,        // Frame in progress
    output unbm_pkg::unbm_rxres_type     rx_result         // Accepted frame
);
    import unbm_pkg::*;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_BITS = 3'b010,
        RX_STOP = 3'b100
    } unbm_rxst_type;

    unbm_rxst_type  state_reg;
    logic [3:0]     cnt_reg;
    logic [2:0]     smp_reg;
    logic [8:0]     shift_reg;
    logic           prev_reg;
    logic           vote;
    logic           bit_end;
    logic           fall;

    assign vote    = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2])
                   | (smp_reg[1] & smp_reg[2]);
    assign bit_end = sample_tick && (cnt_reg == UNBM_CNT_LAST);
    assign fall    = prev_reg && !rxd_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b1;
        end else if (sample_tick) begin
            prev_reg <= rxd_level;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_reg <= 3'h7;
        end else if (sample_tick && (cnt_reg == UNBM_SMP_A || cnt_reg == UNBM_SMP_B
                                     || cnt_reg == UNBM_SMP_C)) begin
            smp_reg <= {smp_reg[1:0], rxd_level};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RX_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= UNBM_SHIFT_RST;
        end else begin
            case (state_reg)
                RX_IDLE: begin
                    if (sample_tick && fall && rx_enable) begin
                        state_reg <= RX_BITS;
                        cnt_reg   <= 4'h0;
                        shift_reg <= UNBM_SHIFT_RST;
                    end
                end
                RX_BITS: begin
                    if (sample_tick) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (bit_end) begin
                        if (shift_reg == UNBM_SHIFT_RST && vote) begin
                            state_reg <= RX_IDLE;
                        end else begin
                            shift_reg <= {vote, shift_reg[8:1]};
                            if (!shift_reg[0]) begin
                                state_reg <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (sample_tick) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (bit_end) begin
                        state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_result <= '0;
            rx_active <= 1'b0;
        end else begin
            rx_active      <= (state_reg != RX_IDLE);
            rx_result.load <= 1'b0;
            if (state_reg == RX_BITS && bit_end && !shift_reg[0]
                && shift_reg != UNBM_SHIFT_RST) begin
                if (!rx_done_flag && (!multiproc_filter || vote)) begin
                    rx_result.load  <= 1'b1;
                    rx_result.ninth <= vote;
                    rx_result.data  <= shift_reg[8:1];
                end
            end
        end
    end

endmodule : unbm_rx

// ### rtl/unbm_top.sv
// Purpose: nine-bit serial port, modes 2 and 3, with AXI4-Lite registers
// Assumes: timer1_ovf is a one-cycle pulse on aclk; rxd is asynchronous
// Notes: aclk is the oscillator; all outputs are registered
`timescale 1ns/10ps
module unbm_top (
    input  wire logic                    aclk,       // Clock, oscillator
    input  wire logic                    aresetn,    // Sync reset, low
    input  unbm_pkg::unbm_axireq_type    axi_req,    // AXI4-Lite from master
    output unbm_pkg::unbm_axirsp_type    axi_rsp,    // AXI4-Lite to master
    input  wire logic                    timer1_ovf, // Timer 1 overflow pulse
    input  wire logic                    rxd,        // Receive line pin
    output logic                         txd         // Transmit line pin
);
    import unbm_pkg::*;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_START = 3'b010,
        TX_DATA  = 3'b100
    } unbm_txst_type;

    // Control bits
    logic           mode3_reg;
    logic           dbl_reg;
    logic           multiproc_filter;
    logic           ren_reg;
    logic           tx_ninth_bit;
    logic           rx_ninth_bit;
    logic           tx_done_flag;
    logic           rx_done_flag;
    logic [7:0]     serial_buffer;
    logic [7:0]     serial_control;

    // Bus slave state
    logic                  aw_held_reg;
    logic [UNBM_AW-1:0]    awaddr_reg;
    logic                  w_held_reg;
    logic [31:0]           wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  aw_take;
    logic                  w_take;
    logic                  ar_take;
    logic                  wr_do;
    logic                  wr_ctrl;
    logic                  wr_buf;
    logic                  wr_hit;
    logic [31:0]           rd_data;
    logic [1:0]            rd_resp;

    // Rate generation
    logic           src_pulse;
    logic           half_reg;
    logic           tick_reg;
    logic [3:0]     txcnt_reg;
    logic           bit_tick;

    // Transmitter
    unbm_txst_type  txst_reg;
    logic [8:0]     txsr_reg;
    logic           txreq_reg;
    logic           shifted_reg;
    logic           tx_last;

    // Receive line synchroniser
    logic           rxd_s1_reg;
    logic           rxd_s2_reg;
    logic           rxd_s3_reg;
    logic           rxd_level_reg;

    logic           rx_active;
    unbm_rxres_type rx_result;

    // ---------------- AXI4-Lite slave ----------------

    assign aw_take = axi_req.awvalid && axi_rsp.awready;
    assign w_take  = axi_req.wvalid && axi_rsp.wready;
    assign ar_take = axi_req.arvalid && axi_rsp.arready;
    assign wr_do   = aw_held_reg && w_held_reg && !axi_rsp.bvalid;
    assign wr_hit  = (awaddr_reg == UNBM_CTRL_OFS) || (awaddr_reg == UNBM_BUF_OFS)
                   || (awaddr_reg == UNBM_STAT_OFS);
    assign wr_ctrl = wr_do && wstrb_reg[0] && (awaddr_reg == UNBM_CTRL_OFS);
    assign wr_buf  = wr_do && wstrb_reg[0] && (awaddr_reg == UNBM_BUF_OFS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg     <= 1'b0;
            awaddr_reg      <= '0;
            axi_rsp.awready <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= axi_req.awaddr;
            end else if (wr_do) begin
                aw_held_reg <= 1'b0;
            end
            axi_rsp.awready <= !(aw_take || (aw_held_reg && !wr_do));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg     <= 1'b0;
            wdata_reg      <= 32'h0000_0000;
            wstrb_reg      <= 4'h0;
            axi_rsp.wready <= 1'b0;
        end else begin
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= axi_req.wdata;
                wstrb_reg  <= axi_req.wstrb;
            end else if (wr_do) begin
                w_held_reg <= 1'b0;
            end
            axi_rsp.wready <= !(w_take || (w_held_reg && !wr_do));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            axi_rsp.bvalid <= 1'b0;
            axi_rsp.bresp  <= UNBM_OKAY;
        end else if (wr_do) begin
            axi_rsp.bvalid <= 1'b1;
            axi_rsp.bresp  <= wr_hit ? UNBM_OKAY : UNBM_SLVERR;
        end else if (axi_req.bready) begin
            axi_rsp.bvalid <= 1'b0;
        end
    end

    assign serial_control = {dbl_reg, mode3_reg, multiproc_filter, ren_reg,
                             tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = UNBM_OKAY;
        case (axi_req.araddr)
            UNBM_CTRL_OFS: begin
                rd_data = {24'h00_0000, serial_control};
            end
            UNBM_BUF_OFS: begin
                rd_data = {24'h00_0000, serial_buffer};
            end
            UNBM_STAT_OFS: begin
                rd_data = {30'h0000_0000, rx_active, (txst_reg != TX_IDLE)};
            end
            default: begin
                rd_resp = UNBM_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            axi_rsp.rvalid  <= 1'b0;
            axi_rsp.rdata   <= 32'h0000_0000;
            axi_rsp.rresp   <= UNBM_OKAY;
            axi_rsp.arready <= 1'b0;
        end else begin
            if (ar_take) begin
                axi_rsp.rvalid <= 1'b1;
                axi_rsp.rdata  <= rd_data;
                axi_rsp.rresp  <= rd_resp;
            end else if (axi_req.rready) begin
                axi_rsp.rvalid <= 1'b0;
            end
            axi_rsp.arready <= !(ar_take || (axi_rsp.rvalid && !axi_req.rready));
        end
    end

    // ---------------- Control register ----------------

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbl_reg          <= UNBM_CTRL_RST[UNBM_DBL_BIT];
            mode3_reg        <= UNBM_CTRL_RST[UNBM_MODE3_BIT];
            multiproc_filter <= UNBM_CTRL_RST[UNBM_MPF_BIT];
            ren_reg          <= UNBM_CTRL_RST[UNBM_REN_BIT];
            tx_ninth_bit     <= UNBM_CTRL_RST[UNBM_TB9_BIT];
        end else if (wr_ctrl) begin
            dbl_reg          <= wdata_reg[UNBM_DBL_BIT];
            mode3_reg        <= wdata_reg[UNBM_MODE3_BIT];
            multiproc_filter <= wdata_reg[UNBM_MPF_BIT];
            ren_reg          <= wdata_reg[UNBM_REN_BIT];
            tx_ninth_bit     <= wdata_reg[UNBM_TB9_BIT];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_done_flag <= UNBM_CTRL_RST[UNBM_TXF_BIT];
        end else if (tx_last) begin
            tx_done_flag <= 1'b1;
        end else if (wr_ctrl && !wdata_reg[UNBM_TXF_BIT]) begin
            tx_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_done_flag <= UNBM_CTRL_RST[UNBM_RXF_BIT];
        end else if (rx_result.load) begin
            rx_done_flag <= 1'b1;
        end else if (wr_ctrl && !wdata_reg[UNBM_RXF_BIT]) begin
            rx_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ninth_bit  <= UNBM_CTRL_RST[UNBM_RB9_BIT];
            serial_buffer <= 8'h00;
        end else if (rx_result.load) begin
            rx_ninth_bit  <= rx_result.ninth;
            serial_buffer <= rx_result.data;
        end
    end

    // ---------------- Rate generation ----------------

    // Mode 2 counts oscillator cycles, mode 3 counts timer 1 overflows
    assign src_pulse = mode3_reg ? timer1_ovf : 1'b1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (src_pulse) begin
                if (dbl_reg) begin
                    tick_reg <= 1'b1;
                end else begin
                    half_reg <= !half_reg;
                    tick_reg <= half_reg;
                end
            end
        end
    end

    // Free-running divide-by-16 that paces the transmitter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txcnt_reg <= 4'h0;
        end else if (tick_reg) begin
            txcnt_reg <= txcnt_reg + 4'h1;
        end
    end

    assign bit_tick = tick_reg && (txcnt_reg == UNBM_CNT_LAST);

    // ---------------- Transmitter ----------------

    assign tx_last = bit_tick && (txst_reg == TX_DATA) && shifted_reg
                   && (txsr_reg[8:2] == 7'h00) && txsr_reg[1];

    // A buffer write during a frame reloads the shift register as it stands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txst_reg    <= TX_IDLE;
            txsr_reg    <= 9'h000;
            txreq_reg   <= 1'b0;
            shifted_reg <= 1'b0;
        end else begin
            case (txst_reg)
                TX_IDLE: begin
                    if (bit_tick && txreq_reg) begin
                        txst_reg  <= TX_START;
                        txreq_reg <= 1'b0;
                    end
                end
                TX_START: begin
                    if (bit_tick) begin
                        txst_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_last) begin
                        txsr_reg    <= {1'b0, txsr_reg[8:1]};
                        txst_reg    <= TX_IDLE;
                        shifted_reg <= 1'b0;
                    end else if (bit_tick) begin
                        txsr_reg    <= {!shifted_reg, txsr_reg[8:1]};
                        shifted_reg <= 1'b1;
                    end
                end
                default: begin
                    txst_reg <= TX_IDLE;
                end
            endcase
            if (wr_buf) begin
                txsr_reg  <= {tx_ninth_bit, wdata_reg[7:0]};
                txreq_reg <= 1'b1;
            end
        end
    end

    // Start bit while gated on, shift output in data phase, else idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txd <= 1'b1;
        end else begin
            txd <= (txst_reg == TX_IDLE)
                 || ((txst_reg == TX_DATA) && txsr_reg[0]);
        end
    end

    // ---------------- Receiver ----------------

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxd_s1_reg    <= 1'b1;
            rxd_s2_reg    <= 1'b1;
            rxd_s3_reg    <= 1'b1;
            rxd_level_reg <= 1'b1;
        end else begin
            rxd_s1_reg <= rxd;
            rxd_s2_reg <= rxd_s1_reg;
            rxd_s3_reg <= rxd_s2_reg;
            if (rxd_s2_reg == rxd_s3_reg) begin
                rxd_level_reg <= rxd_s3_reg;
            end
        end
    end

    unbm_rx u_rx (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .sample_tick      (tick_reg),
        .rxd_level        (rxd_level_reg),
        .rx_enable        (ren_reg),
        .multiproc_filter (multiproc_filter),
        .rx_done_flag     (rx_done_flag),
        .rx_active        (rx_active),
        .rx_result        (rx_result)
    );

endmodule : unbm_top

// ### dv/unbm_checker.sv
// Purpose: port checks for the nine-bit serial port
// Assumes: one clock, sync low reset
// Notes: bound to unbm_top
`timescale 1ns/10ps
module unbm_checker (
    input wire logic                aclk,       // Clock
    input wire logic                aresetn,    // Reset, low
    input unbm_pkg::unbm_axireq_type axi_req,   // Bus request
    input unbm_pkg::unbm_axirsp_type axi_rsp,   // Bus response
    input wire logic                timer1_ovf, // Overflow
    input wire logic                rxd,        // Receive line
    input wire logic                txd         // Transmit line
);
    import unbm_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    sequence w_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    reset_idle_a: assert property ($rose(aresetn) |-> txd)
        else $error("txd not idle");
    bit_width_a: assert property ($changed(txd) |=> $stable(txd)[*8])
        else $error("txd bit too short");
    write_resp_a: assert property (w_take |-> ##[1:2] axi_rsp.bvalid)
        else $error("no write response");
    bad_write_a: assert property (w_take ##0 axi_req.awaddr == 4'hc
        |-> ##2 axi_rsp.bresp == UNBM_SLVERR) else $error("bad write not refused");
    b_release_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("bvalid stuck");
    read_resp_a: assert property (ar_take |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h0)
        else $error("read answer wrong");
    bad_read_a: assert property (ar_take ##0 axi_req.araddr == 4'hc
        |=> axi_rsp.rresp == UNBM_SLVERR) else $error("bad read not refused");
    r_release_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("rvalid stuck");
endmodule : unbm_checker
bind unbm_top unbm_checker u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .timer1_ovf(timer1_ovf), .rxd(rxd), .txd(txd));

// ### dv/unbm_remote.sv
// Purpose: remote serial device on txd/rxd
// Assumes: bt clocks per bit
// Notes: send drives frames, the receiver logs each txd frame
`timescale 1ns/10ps
module unbm_remote (
    input  wire logic       aclk, // Clock
    input  wire logic       txd,  // Line from port
    output logic            rxd,  // Line into port
    input  wire logic [7:0] bt    // Clocks per bit
);
    logic [10:0] got;
    int          nrx = 0;
    initial rxd = 1'b1;
    // A short first bit makes a false start
    task automatic send(input logic [10:0] f, input int low);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat ((i == 0) ? low : int'(bt)) @(posedge aclk);
        end
        rxd <= 1'b1;
    endtask : send
    always begin
        @(negedge txd);
        repeat (bt / 2) @(posedge aclk);
        for (int i = 0; i < 11; i++) begin
            got[i] = txd;
            if (i < 10) repeat (bt) @(posedge aclk);
        end
        nrx++;
    end
endmodule : unbm_remote

// ### dv/unbm_tb.sv
// Purpose: self-checking bench for the nine-bit serial port
// Assumes: remote model on the lines
// Notes: overflow pulses every second clock
`timescale 1ns/10ps
module unbm_tb;
    import unbm_pkg::*;
    logic            aclk, aresetn, rxd, txd;
    logic            ovf = 1'b0;
    logic [7:0]      bt = 8'h10;
    logic [31:0]     d;
    int              mismatches = 0, num_checks = 0, n;
    unbm_axireq_type rq;
    unbm_axirsp_type rs;
    // Rows: control, byte, expected frame
    logic [26:0] rows [5] = '{{8'h88, 8'ha5, 11'h74a}, {8'h80, 8'h3c, 11'h478},
                              {8'h08, 8'h81, 11'h702}, {8'hc0, 8'hff, 11'h5fe},
                              {8'h48, 8'h12, 11'h624}};
    unbm_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
                  .timer1_ovf(ovf), .rxd(rxd), .txd(txd));
    unbm_remote u_rem (.aclk(aclk), .txd(txd), .rxd(rxd), .bt(bt));
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) ovf <= ~ovf;
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        rq.awaddr <= a;
        rq.wdata <= {24'h0, v};
        rq.wstrb <= 4'hf;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
            if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
            if (rs.bvalid) rq.bready <= 1'b0;
            done = rs.bvalid;
        end
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid) v = rs.rdata;
            if (rs.rvalid) rq.rready <= 1'b0;
            done = rs.rvalid;
        end
    endtask : rd
    task automatic rx_case(input logic [7:0] c, input logic [10:0] f, input int low,
                           input logic [7:0] eb, ec);
        wr(UNBM_CTRL_OFS, c);
        u_rem.send(f, low);
        repeat (bt) @(posedge aclk);
        rd(UNBM_BUF_OFS, d);
        chk("rx buf", {24'h0, eb}, d);
        rd(UNBM_CTRL_OFS, d);
        chk("rx ctrl", {24'h0, ec}, d);
        $display("rx case done");
    endtask : rx_case
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (60000) @(posedge aclk);
        mismatches++;
        wrap_up();
    end
    initial begin
        aresetn = 1'b0;
        rq = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(UNBM_CTRL_OFS, d);
        chk("ctrl reset", 32'h0, d);
        rd(4'hc, d);
        chk("unmapped", 32'h0, d);
        rd(UNBM_STAT_OFS, d);
        chk("status reset", 32'h0, d);
        wr(4'hc, 8'hff);
        $display("reset tests done");
        for (int i = 0; i < 5; i++) begin
            bt <= (rows[i][26] ? 8'h10 : 8'h20) << rows[i][25];
            wr(UNBM_CTRL_OFS, rows[i][26:19]);
            n = u_rem.nrx;
            wr(UNBM_BUF_OFS, rows[i][18:11]);
            repeat (3000) if (u_rem.nrx == n) @(posedge aclk);
            chk("tx count", n + 1, u_rem.nrx);
            chk("tx frame", {21'h0, rows[i][10:0]}, {21'h0, u_rem.got});
            rd(UNBM_CTRL_OFS, d);
            chk("tx done", {24'h0, rows[i][26:19] | 8'h02}, d);
            $display("tx row %0d done", i);
        end
        bt <= 8'h10;
        rx_case(8'h90, 11'h6b4, 16, 8'h5a, 8'h95);
        rx_case(8'h95, 11'h622, 16, 8'h5a, 8'h95);
        rx_case(8'hb0, 11'h444, 16, 8'h5a, 8'hb4);
        rx_case(8'hb0, 11'h266, 16, 8'h33, 8'hb5);
        rx_case(8'h90, 11'h7fe, 3, 8'h33, 8'h94);
        rx_case(8'h90, 11'h488, 16, 8'h44, 8'h91);
        wrap_up();
    end
endmodule : unbm_tb
